/* File: qdac_host.sv */
// host model driving the three-wire link
`timescale 1ns/10ps
module qdac_host (
  output logic sclk_out, // shift clock, idle low
  output logic serial_data_in_out, // serial data
  output logic cs_n_out  // chip select
);
  initial begin
    sclk_out = 0;
    serial_data_in_out = 0;
    cs_n_out = 1;
  end
  // msb first; above sixteen bits only the last sixteen stay
  task automatic send(input logic [15:0] w, input int n);
    cs_n_out = 0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in_out = w[i % 16];
      #80 sclk_out = 1;
      #80 sclk_out = 0;
    end
    #40 cs_n_out = 1;
    serial_data_in_out = ~serial_data_in_out; // released line must not look valid
  endtask
  // shift clocks with select high; the device must ignore them
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in_out = ~serial_data_in_out;
      #80 sclk_out = 1;
      #80 sclk_out = 0;
    end
  endtask
endmodule // qdac_host

/* File: qdac_pkg.sv */
// package: constants and carrier types for the quad dac serial load front end
package qdac_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned CH_SEL_LSB  = 12;
  localparam int unsigned CH_SEL_W    = 2;
  localparam logic [11:0] CODE_ZERO   = 12'h000;
  localparam logic [11:0] CODE_MID    = 12'h800;
  localparam logic [15:0] SHIFT_RST   = 16'h0000;
  localparam logic [4:0]  CNT_RST     = 5'h00;

  typedef struct packed {
    logic sclk;
    logic serial_data_in;
    logic cs_n;
    logic load_n;
    logic clear_n;
    logic clear_sel;
  } qdac_pins_type;

  typedef logic [NUM_CH-1:0][CODE_W-1:0] qdac_codes_type;
endpackage

/* File: qdac_serial_load.sv */
// quad dac serial input register, load strobe and clear logic
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module qdac_serial_load
  import qdac_pkg::*;
#(
  parameter int unsigned WORD_BITS = WORD_W,
  parameter int unsigned CODE_BITS = CODE_W,
  parameter int unsigned CHANNELS  = NUM_CH
) (
  input  wire logic                 CORE_CLK_IN,         // core clock, 200 MHz
  input  wire logic                 NRST_IN,             // async reset, active low
  input  wire logic                 SHIFT_CLK_IN,        // serial shift clock pin
  input  wire logic                 SERIAL_DATA_IN_IN,   // serial data pin
  input  wire logic                 CHIP_SELECT_N_IN,    // chip select, active low
  input  wire logic                 DAC_LOAD_STROBE_N_IN, // load strobe, active low
  input  wire logic                 ASYNC_CLEAR_N_IN,    // clear, active low
  input  wire logic                 CLEAR_LEVEL_SELECT_IN, // 1 midscale, 0 zero
  output qdac_pkg::qdac_codes_type  DAC_CODE_OUT,        // per-channel dac codes
  output logic [WORD_W-1:0]         SHIFT_WORD_OUT,      // serial input register
  output logic                      WORD_DONE_OUT,       // pulse: 16 bits framed
  output logic                      LOAD_DONE_OUT        // pulse: dac updated
);
  import qdac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  localparam int unsigned PIN_W = $bits(qdac_pins_type);
  localparam int unsigned CNT_W = $bits(CNT_RST);

  qdac_pins_type    pins_raw;
  qdac_pins_type    pins_s;
  logic [PIN_W-1:0] pins_s_bits;

  assign pins_raw = '{sclk: SHIFT_CLK_IN, serial_data_in: SERIAL_DATA_IN_IN,
                      cs_n: CHIP_SELECT_N_IN, load_n: DAC_LOAD_STROBE_N_IN,
                      clear_n: ASYNC_CLEAR_N_IN, clear_sel: CLEAR_LEVEL_SELECT_IN};

  // the shift clock is a pin like the rest, so its edges are found after the sync
  qdac_sync #(
    .WIDTH    (PIN_W)
  ) u_sync (
    .clk_in   (CORE_CLK_IN),
    .nrst_in  (NRST_IN),
    .async_in (pins_raw),
    .sync_out (pins_s_bits)
  );
  assign pins_s = pins_s_bits;

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised levels
  logic sclk_d_ff;
  logic load_d_ff;
  logic cs_d_ff;

  // reset values match the synchroniser so no false edge follows reset
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sclk_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= pins_s.sclk;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      load_d_ff <= 1'b1;
    end else begin
      load_d_ff <= pins_s.load_n;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cs_d_ff <= 1'b1;
    end else begin
      cs_d_ff <= pins_s.cs_n;
    end
  end

  wire sclk_rise  = pins_s.sclk & ~sclk_d_ff;
  wire shift_en   = sclk_rise & ~pins_s.cs_n;
  wire load_fall  = ~pins_s.load_n & load_d_ff;
  wire cs_rise    = pins_s.cs_n & ~cs_d_ff;
  wire clear_on   = ~pins_s.clear_n;

  //////////////////////////////////////////////////////////////////////////////
  // serial input register and frame tracking
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01,
    FR_FULL  = 2'b11,
    FR_END   = 2'b10
  } qdac_frame_type;

  qdac_frame_type    frame_ff;
  qdac_frame_type    nxt_frame;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;
  logic [CNT_W-1:0]  bit_cnt_ff;
  logic [CNT_W-1:0]  nxt_bit_cnt;
  logic              word_done_ff;
  wire               cnt_full;

  // clear never touches the shift register, so a later load still moves the word
  assign nxt_shift   = shift_en ? {shift_ff[WORD_W-2:0], pins_s.serial_data_in} : shift_ff;
  // count saturates; extra bits simply push the oldest ones out
  assign nxt_bit_cnt = cs_rise ? CNT_RST :
                       (shift_en && bit_cnt_ff != CNT_W'(WORD_BITS)) ? bit_cnt_ff + CNT_W'(1) :
                       bit_cnt_ff;
  assign cnt_full    = (nxt_bit_cnt == CNT_W'(WORD_BITS));

  always_comb begin
    nxt_frame = frame_ff;
    case (frame_ff)
      FR_IDLE: begin
        if (!pins_s.cs_n) begin
          nxt_frame = FR_SHIFT;
        end
      end
      FR_SHIFT: begin
        // a short frame ends quietly: the host gets no completion pulse
        if (cs_rise) begin
          nxt_frame = FR_IDLE;
        end else if (cnt_full) begin
          nxt_frame = FR_FULL;
        end
      end
      FR_FULL: begin
        if (cs_rise) begin
          nxt_frame = FR_END;
        end
      end
      FR_END: begin
        nxt_frame = FR_IDLE;
      end
      default: begin
        nxt_frame = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_ff <= SHIFT_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      bit_cnt_ff <= CNT_RST;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      frame_ff <= FR_IDLE;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      word_done_ff <= 1'b0;
    end else begin
      word_done_ff <= cs_rise && (frame_ff == FR_FULL);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // dac data registers
  function automatic logic [CODE_W-1:0] clear_code(input logic sel);
    clear_code = sel ? CODE_MID : CODE_ZERO;
  endfunction

  wire [CH_SEL_W-1:0] ch_sel  = shift_ff[CH_SEL_LSB +: CH_SEL_W];
  wire [CODE_W-1:0]   ld_code = shift_ff[CODE_W-1:0];
  // clear follows the select level live for as long as it is held
  wire [CODE_W-1:0]   clr_code = clear_code(pins_s.clear_sel);

  logic [CHANNELS-1:0] load_hit;

  always_comb begin
    load_hit = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      load_hit[i] = load_fall && (ch_sel == CH_SEL_W'(i));
    end
  end

  qdac_codes_type dac_ff;
  qdac_codes_type nxt_dac;
  logic           load_done_ff;

  always_comb begin
    nxt_dac = dac_ff;
    for (int i = 0; i < CHANNELS; i++) begin
      if (clear_on) begin
        nxt_dac[i] = clr_code;
      end else if (load_hit[i]) begin
        nxt_dac[i] = ld_code;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dac_ff <= '0;
    end else begin
      dac_ff <= nxt_dac;
    end
  end

  // a load swallowed by clear reports nothing
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      load_done_ff <= 1'b0;
    end else begin
      load_done_ff <= load_fall & ~clear_on;
    end
  end

  assign DAC_CODE_OUT   = dac_ff;
  assign SHIFT_WORD_OUT = shift_ff;
  assign WORD_DONE_OUT  = word_done_ff;
  assign LOAD_DONE_OUT  = load_done_ff;
endmodule // qdac_serial_load

/* File: qdac_serial_load_bench.sv */
// self-checking bench for the quad dac serial load block
`timescale 1ns/10ps
module qdac_serial_load_bench;
  import qdac_pkg::*;
  logic clk = 0, nrst = 0, ld_n = 1, clr_n = 1, sel = 0, sclk, serial_data_in, cs_n;
  qdac_codes_type dac;
  logic [15:0]    word, w, m_word;
  logic [47:0]    m_dac = '0;
  int             n_errors = 0, compares = 0, n_wd = 0, n_ld = 0;
  logic           wd, ldd;
  always #2.5 clk = ~clk;
  qdac_host i_qdac_host (.sclk_out(sclk), .serial_data_in_out(serial_data_in), .cs_n_out(cs_n));
  qdac_serial_load i_qdac_serial_load (.CORE_CLK_IN(clk), .NRST_IN(nrst),
    .SHIFT_CLK_IN(sclk), .SERIAL_DATA_IN_IN(serial_data_in), .CHIP_SELECT_N_IN(cs_n),
    .DAC_LOAD_STROBE_N_IN(ld_n), .ASYNC_CLEAR_N_IN(clr_n), .CLEAR_LEVEL_SELECT_IN(sel),
    .DAC_CODE_OUT(dac), .SHIFT_WORD_OUT(word), .WORD_DONE_OUT(wd), .LOAD_DONE_OUT(ldd));
  always @(negedge clk) begin
    if (wd === 1'b1) n_wd++;
    if (ldd === 1'b1) n_ld++;
  end
////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic hit);
    @(posedge clk) #1 ld_n = 0;
    repeat (4) @(posedge clk);
    #1 ld_n = 1; // word left untouched while low
    if (hit) m_dac[12 * m_word[13:12] +: 12] = m_word[11:0];
    repeat (6) @(posedge clk);
    chk(dac, m_dac);
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic clear_to(input logic lvl);
    @(posedge clk) #1 sel = lvl;
    clr_n = 0;
    repeat (8) @(posedge clk);
  endtask
////////////////////////////////////////
  initial begin
    w = $urandom(35);
    repeat (3) @(posedge clk);
    #1 nrst = 1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      w[13:12] = k[1:0];
      @(posedge clk) #1;
      i_qdac_host.send(w, 16 + 4 * (k / 4));
      m_word = w;
      repeat (6) @(posedge clk);
      chk(48'(word), 48'(m_word));
      load(1);
    end
    $display("load test done");
    @(posedge clk) #1;
    w = $urandom;
    i_qdac_host.send(w, 8);
    m_word = {m_word[7:0], w[7:0]};
    repeat (6) @(posedge clk);
    chk(48'(word), 48'(m_word));
    #1 i_qdac_host.idle_clocks(6);
    repeat (6) @(posedge clk);
    chk(48'(word), 48'(m_word));
    chk(48'(n_wd), 48'(8));
    $display("frame test done");
    clear_to(1);
    chk(dac, {4{CODE_MID}});
    clear_to(0);
    m_dac = '0;
    chk(dac, m_dac);
    load(0);
    chk(48'(word), 48'(m_word));
    #1 clr_n = 1;
    load(1);
    chk(48'(n_ld), 48'(9));
    $display("clear test done");
    report_and_stop;
  end
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule // qdac_serial_load_bench

/* File: qdac_serial_load_props.sv */
// port assertions for the quad dac serial load block
`timescale 1ns/10ps
module qdac_serial_load_props
  import qdac_pkg::*;
(
  input wire logic                     CORE_CLK_IN, // clock
  input wire logic                     NRST_IN, // reset
  input wire logic                     SERIAL_DATA_IN_IN, // data
  input wire logic                     CHIP_SELECT_N_IN, // select
  input wire logic                     ASYNC_CLEAR_N_IN, // clear
  input wire logic                     CLEAR_LEVEL_SELECT_IN, // level
  input wire logic                     DAC_LOAD_STROBE_N_IN, // load
  input wire qdac_pkg::qdac_codes_type DAC_CODE_OUT, // codes
  input wire logic [WORD_W-1:0]        SHIFT_WORD_OUT, // word
  input wire logic                     WORD_DONE_OUT, // pulse
  input wire logic                     LOAD_DONE_OUT // pulse
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
////////////////////////////////////////
  // five samples cover the pin synchroniser lag
  a_clear_zero: assert property ((!ASYNC_CLEAR_N_IN && !CLEAR_LEVEL_SELECT_IN)[*5]
    |-> DAC_CODE_OUT == '0) else $error("clear zero wrong");
  a_clear_mid: assert property ((!ASYNC_CLEAR_N_IN && CLEAR_LEVEL_SELECT_IN)[*5]
    |-> DAC_CODE_OUT == {4{CODE_MID}}) else $error("clear mid wrong");
  a_shift_hold: assert property (CHIP_SELECT_N_IN[*5] |=> $stable(SHIFT_WORD_OUT))
    else $error("word moved while deselected");
  a_bit_order: assert property ($changed(SHIFT_WORD_OUT) |->
    {SHIFT_WORD_OUT[15:1], 1'b0} == ($past(SHIFT_WORD_OUT) << 1)
    && SHIFT_WORD_OUT[0] == $past(SERIAL_DATA_IN_IN, 4)) else $error("bad shift");
  a_load_acts: assert property ($fell(DAC_LOAD_STROBE_N_IN) && ASYNC_CLEAR_N_IN
    |-> ##[1:5] (LOAD_DONE_OUT || !ASYNC_CLEAR_N_IN)) else $error("load lost");
  a_load_code: assert property (LOAD_DONE_OUT |->
    DAC_CODE_OUT[SHIFT_WORD_OUT[13:12]] == SHIFT_WORD_OUT[11:0]) else $error("bad code");
  a_word_end: assert property (WORD_DONE_OUT |-> CHIP_SELECT_N_IN ##1 !WORD_DONE_OUT)
    else $error("word pulse wrong");
  a_clear_wins: assert property ((!ASYNC_CLEAR_N_IN)[*5] |-> !LOAD_DONE_OUT)
    else $error("load during clear");
  cover property (WORD_DONE_OUT);
  cover property (LOAD_DONE_OUT);
  cover property (DAC_CODE_OUT == {4{CODE_MID}});
endmodule // qdac_serial_load_props
bind qdac_serial_load qdac_serial_load_props i_props (.*);

/* File: qdac_sync.sv */
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module qdac_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_in,   // core clock
  input  wire logic             nrst_in,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic      [WIDTH-1:0] sync_out  // levels safe to use
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // idle level is all ones so strobes and select read inactive after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // qdac_sync
